// *** core/sipo_latch.sv ***
// Shift register plus storage register with three-state parallel outputs.
// Assumes all pins arrive asynchronously and are sampled on clk (250 MHz);
// the pin clocks must therefore be much slower than clk.
//
// Function
// [R1] Eight-stage shift register feeds eight-bit storage
// [R2] Separate shift and storage clock inputs
// [R3] Active-low clear overrides shifting
// [R4] Serial cascade output from shift register
// [R5] Output enable high floats parallel outputs only
// [R6] Both clocks act on rising edges
// [R7] Tied clocks: storage takes pre-edge shift value
// [R8] No defined power-on state for contents
// [R9] Outputs drive high, low or float
// [R10] Shift edge loads serial input, stages advance
// [R11] Storage edge copies all stages unconditionally
// [R12] Host gives shift-to-storage setup margin
// [R13] Clear zeroes stages, storage untouched
// [R14] Cascade is last stage; outputs in order
`timescale 1ns/1ps
module sipo_latch #(
  parameter int WIDTH = sipo_pkg::SIPO_STAGES
) (
  // System
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // Pins from the host
  input  wire logic             shift_clock,
  input  wire logic             store_clock,
  input  wire logic             shift_clear_n,
  input  wire logic             shift_data_in,
  input  wire logic             out_enable_n,
  // Pins to the outside
  output logic [WIDTH-1:0]      parallel_out,
  output logic [WIDTH-1:0]      parallel_oe,
  output logic                  cascade_out
);
  import sipo_pkg::*;

  typedef struct packed {
    logic [SIPO_SYNC_DEPTH-1:0] s_clk;
    logic [SIPO_SYNC_DEPTH-1:0] r_clk;
    logic [SIPO_SYNC_DEPTH-1:0] clr_n;
    logic [SIPO_SYNC_DEPTH-1:0] din;
    logic [SIPO_SYNC_DEPTH-1:0] oe_n;
    logic                       s_lvl;
    logic                       r_lvl;
    logic                       clr_lvl;
    logic                       din_lvl;
    logic                       oe_lvl;
    logic [WIDTH-1:0]           shift;
    logic [WIDTH-1:0]           store;
  } sipo_state_t;

  sipo_state_t st_reg;
  sipo_state_t st_next;
  logic        s_rise;
  logic        r_rise;
  logic        s_cur;
  logic        r_cur;
  logic        clr_cur;

  // Filtered level: a change counts once stages two and three agree
  function automatic logic sipo_filt(input logic [SIPO_SYNC_DEPTH-1:0] sh, input logic prev);
    sipo_filt = (sh[2] == sh[1]) ? sh[2] : prev;
  endfunction

  always_comb begin
    st_next = st_reg;
    st_next.s_clk = {st_reg.s_clk[1:0], shift_clock};
    st_next.r_clk = {st_reg.r_clk[1:0], store_clock};
    st_next.clr_n = {st_reg.clr_n[1:0], shift_clear_n};
    st_next.din   = {st_reg.din[1:0], shift_data_in};
    st_next.oe_n  = {st_reg.oe_n[1:0], out_enable_n};
    s_cur   = sipo_filt(st_reg.s_clk, st_reg.s_lvl);
    r_cur   = sipo_filt(st_reg.r_clk, st_reg.r_lvl);
    clr_cur = sipo_filt(st_reg.clr_n, st_reg.clr_lvl);
    st_next.s_lvl   = s_cur;
    st_next.r_lvl   = r_cur;
    st_next.clr_lvl = clr_cur;
    st_next.din_lvl = sipo_filt(st_reg.din, st_reg.din_lvl);
    st_next.oe_lvl  = sipo_filt(st_reg.oe_n, st_reg.oe_lvl);
    // Rising edges only; falling edges do nothing
    s_rise = s_cur & ~st_reg.s_lvl; // R6
    r_rise = r_cur & ~st_reg.r_lvl; // R6
    // Storage copies the old shift value, so tied clocks lag by one pulse
    if (r_rise) begin
      st_next.store = st_reg.shift; // R11 R7 R1 R2
    end
    // Clear is level-acting and beats any shift edge
    if (!clr_cur) begin
      st_next.shift = WIDTH'(SIPO_CLEAR_VALUE); // R3 R13
    end else if (s_rise) begin
      st_next.shift = {st_reg.shift[WIDTH-2:0], st_reg.din_lvl}; // R10 R2
    end
  end

  // Reset only settles the samplers; data content stays as it was
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg.s_clk   <= '0;
      st_reg.r_clk   <= '0;
      st_reg.clr_n   <= '1;
      st_reg.din     <= '0;
      st_reg.oe_n    <= '1;
      st_reg.s_lvl   <= 1'b0;
      st_reg.r_lvl   <= 1'b0;
      st_reg.clr_lvl <= 1'b1;
      st_reg.din_lvl <= 1'b0;
      st_reg.oe_lvl  <= 1'b1;
      st_reg.shift   <= st_next.shift; // R8
      st_reg.store   <= st_next.store; // R8
    end else begin
      st_reg <= st_next;
    end
  end

  // Stage 0 is the first output bit; cascade is the last stage
  assign parallel_out = st_reg.store; // R14 R9
  assign parallel_oe  = {WIDTH{~st_reg.oe_lvl}}; // R5 R9
  assign cascade_out  = st_reg.shift[WIDTH-1]; // R4 R14

  // Qualified pin events; the two edges are one clk wide after the filter, clear is a level
  sequence s_shift_edge;
    s_rise && clr_cur;
  endsequence
  sequence s_store_edge;
    r_rise;
  endsequence
  sequence s_clear_on;
    !clr_cur;
  endsequence

  // Clear empties the chain; storage may still move on its own edge
  property p_clear_zeroes;
    @(posedge clk) disable iff (sys_rst)
      s_clear_on |=> (cascade_out == 1'b0 && ($past(r_rise) || $stable(parallel_out)));
  endproperty
  a_clear_zeroes: assert property (p_clear_zeroes) else $error("clear did not zero"); // R13

  // Every stage stays zero under clear, even across a shift edge
  property p_clear_all;
    @(posedge clk) disable iff (sys_rst)
      s_clear_on |=> (st_reg.shift == '0);
  endproperty
  a_clear_all: assert property (p_clear_all) else $error("clear left a stage set"); // R3

  // Each stage takes its neighbour on a shift edge
  property p_shift_step;
    @(posedge clk) disable iff (sys_rst)
      s_shift_edge |=> (st_reg.shift[WIDTH-1:1] == $past(st_reg.shift[WIDTH-2:0]));
  endproperty
  a_shift_step: assert property (p_shift_step) else $error("shift did not advance"); // R10

  // First stage loads the filtered serial level
  property p_first_stage;
    @(posedge clk) disable iff (sys_rst)
      s_shift_edge |=> (st_reg.shift[0] == $past(st_reg.din_lvl));
  endproperty
  a_first_stage: assert property (p_first_stage) else $error("first stage missed data"); // R10

  // Cascade shows the stage that was next to last before the edge
  property p_cascade_step;
    @(posedge clk) disable iff (sys_rst)
      s_shift_edge |=> (cascade_out == $past(st_reg.shift[WIDTH-2]));
  endproperty
  a_cascade_step: assert property (p_cascade_step) else $error("cascade not last stage"); // R4

  // No edge and no clear: the whole chain holds, falling edges included
  property p_hold_no_edge;
    @(posedge clk) disable iff (sys_rst)
      (!s_rise && clr_cur) |=> $stable(st_reg.shift);
  endproperty
  a_hold_no_edge: assert property (p_hold_no_edge) else $error("shift moved without edge"); // R6

  // Clock pin level follows once flops two and three agree
  property p_clk_filter;
    @(posedge clk) disable iff (sys_rst)
      (st_reg.s_clk[2] == st_reg.s_clk[1]) |=> (st_reg.s_lvl == $past(st_reg.s_clk[2]));
  endproperty
  a_clk_filter: assert property (p_clk_filter) else $error("clock filter wrong"); // R6

  // Data pin filter, same agreement rule as the clocks
  property p_din_filter;
    @(posedge clk) disable iff (sys_rst)
      (st_reg.din[2] == st_reg.din[1]) |=> (st_reg.din_lvl == $past(st_reg.din[2]));
  endproperty
  a_din_filter: assert property (p_din_filter) else $error("data filter wrong"); // R10

  // Storage takes the whole chain as it stood before its edge
  property p_store_copy;
    @(posedge clk) disable iff (sys_rst)
      s_store_edge |=> (parallel_out == $past(st_reg.shift));
  endproperty
  a_store_copy: assert property (p_store_copy) else $error("storage missed copy"); // R11

  // Storage never moves without its own edge
  property p_store_hold;
    @(posedge clk) disable iff (sys_rst)
      !r_rise |=> $stable(parallel_out);
  endproperty
  a_store_hold: assert property (p_store_hold) else $error("storage changed"); // R2

  // Tied clocks: storage gets the old chain while the chain advances
  property p_tied_lag;
    @(posedge clk) disable iff (sys_rst)
      (s_shift_edge ##0 s_store_edge) |=> (parallel_out == $past(st_reg.shift) &&
        parallel_out[WIDTH-2:0] == st_reg.shift[WIDTH-1:1]);
  endproperty
  a_tied_lag: assert property (p_tied_lag) else $error("tied clocks did not lag"); // R7

  // Settled high enable pin floats all parallel outputs one clk later
  property p_oe_float;
    @(posedge clk) disable iff (sys_rst)
      (st_reg.oe_n[2] && st_reg.oe_n[1]) |=> (parallel_oe == '0);
  endproperty
  a_oe_float: assert property (p_oe_float) else $error("outputs driven while off"); // R5

  // Settled low enable pin drives all outputs one clk later
  property p_oe_drive;
    @(posedge clk) disable iff (sys_rst)
      (!st_reg.oe_n[2] && !st_reg.oe_n[1]) |=> (parallel_oe == '1);
  endproperty
  a_oe_drive: assert property (p_oe_drive) else $error("outputs not driven"); // R9
endmodule

// *** core/sipo_pkg.sv ***
// Package for the serial-in, parallel-out output latch.
// Assumes a single system clock; pins are sampled into that domain.
package sipo_pkg;
  localparam int SIPO_STAGES = 8;
  localparam int SIPO_SYNC_DEPTH = 3;
  localparam logic [7:0] SIPO_CLEAR_VALUE = 8'h00;
  localparam int SIPO_LAST_POS = 7;
  localparam int SIPO_FIRST_POS = 0;
endpackage

// *** sim/sipo_host.sv ***
// Host model driving the latch pins from clk-timed tasks.
// Assumes the latch samples its pins on clk; pulse levels stand 4 clk, static levels 8 clk.
`timescale 1ns/1ps
module sipo_host (
  // System
  input  wire logic clk,
  // Pins to the latch
  output logic      shift_clock,
  output logic      store_clock,
  output logic      shift_clear_n,
  output logic      shift_data_in,
  output logic      out_enable_n
);
  // Idle pins; contents stay unknown until loaded
  initial begin
    {shift_clock, store_clock, shift_data_in} = 3'h0;
    {shift_clear_n, out_enable_n} = 2'h3;
  end
  // Drive just after an edge, never on it
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Data settles 4 clk before the edge; the selected shift and store clocks rise and fall together
  task automatic pulse(input logic sh, input logic st, input logic d);
    shift_data_in = d;
    hold(4);
    shift_clock = sh;
    store_clock = st;
    hold(4);
    {shift_clock, store_clock} = 2'h0;
    hold(4);
  endtask
  // Static levels, long enough for the pin filter
  task automatic levels(input logic clr_n, input logic oe_n);
    shift_clear_n = clr_n;
    out_enable_n = oe_n;
    hold(8);
  endtask
endmodule

// *** sim/testbench.sv ***
// Self-checking bench for the output latch.
// Assumes the host model owns every pin; the bench only drives clk and reset.
`timescale 1ns/1ps
module testbench;
  import sipo_pkg::*;
  logic       clk = 1'h0;
  logic       sys_rst = 1'h1;
  logic       sh_c, st_c, clr_n, d_in, oe_n, casc;
  logic [7:0] p_out, p_oe;
  int         n_fail = 0;
  int         tests_run = 0;
  int         cycles = 0;
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
  always #2 clk = ~clk;
  sipo_host host (.clk(clk), .shift_clock(sh_c), .store_clock(st_c), .shift_clear_n(clr_n),
    .shift_data_in(d_in), .out_enable_n(oe_n));
  sipo_latch uut (.clk(clk), .sys_rst(sys_rst), .shift_clock(sh_c), .store_clock(st_c),
    .shift_clear_n(clr_n), .shift_data_in(d_in), .out_enable_n(oe_n),
    .parallel_out(p_out), .parallel_oe(p_oe), .cascade_out(casc));
  // First bit sent lands in the last stage
  task automatic shift_byte(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) host.pulse(1'h1, 1'h0, v[i]);
  endtask
  // Clear and store first so every check sees defined contents
  task automatic t_load();
    host.levels(1'h0, 1'h0);
    host.levels(1'h1, 1'h0);
    host.pulse(1'h0, 1'h1, 1'h0);
    `CHK("defined", SIPO_CLEAR_VALUE, p_out)
    shift_byte(8'hA5);
    `CHK("cascade", 1'h1, casc)
    `CHK("held", SIPO_CLEAR_VALUE, p_out)
    host.pulse(1'h0, 1'h1, 1'h0);
    `CHK("parallel", 8'hA5, p_out)
    `CHK("oe on", 8'hFF, p_oe)
  endtask
  task automatic t_oe();
    host.levels(1'h1, 1'h1);
    `CHK("oe off", 8'h00, p_oe)
    `CHK("cascade kept", 1'h1, casc)
    host.levels(1'h1, 1'h0);
    `CHK("oe back", 8'hFF, p_oe)
  endtask
  task automatic t_clear();
    host.levels(1'h0, 1'h0);
    `CHK("clear cascade", 1'h0, casc)
    `CHK("store kept", 8'hA5, p_out)
    host.pulse(1'h1, 1'h0, 1'h1);
    host.levels(1'h1, 1'h0);
    host.pulse(1'h0, 1'h1, 1'h1);
    `CHK("cleared", SIPO_CLEAR_VALUE, p_out)
  endtask
  // Tied clocks store the pre-edge contents
  task automatic t_tied();
    shift_byte(8'h3C);
    `CHK("not stored", SIPO_CLEAR_VALUE, p_out)
    host.pulse(1'h1, 1'h1, 1'h1);
    `CHK("tied", 8'h3C, p_out)
    host.pulse(1'h0, 1'h1, 1'h0);
    `CHK("advanced", 8'h79, p_out)
  endtask
  // Mid-run reset floats outputs but keeps contents
  task automatic t_reset();
    sys_rst = 1'h1;
    host.hold(2);
    `CHK("reset float", 8'h00, p_oe)
    sys_rst = 1'h0;
    host.hold(8);
    `CHK("reset kept", 8'h79, p_out)
    `CHK("reset drive", 8'hFF, p_oe)
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Whole run needs under 600 clk
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      complete_run();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    #1 sys_rst = 1'h0;
    host.hold(2);
    t_load();
    t_oe();
    t_clear();
    t_tied();
    t_reset();
    complete_run();
  end
endmodule
